/* core/mvu_move_unit.sv */
// matrix-to-vector move unit: decode, address generation and vector writeback
//
// Summary of operation
// - 8-bit four-slice: offset is two-bit field x4
// - 16-bit four-slice: offset is one-bit field x4
// - 32/64-bit four-slice: offset fixed at zero
// - base slice aligned index plus offset, mod slices
// - four-slice 64-bit at 128-bit length undefined
// - cycle count independent of data and flags
// - exception response independent of data and flags
// - array select register from 010 plus field
// - array offset is three-bit unsigned, 0 to 7
// - array stride vl/8/nreg, start mod stride
// - two-register array form reads each half
// - four-register array form reads each quarter
// - destination base gets one or two zeros
// - multi-register forms undefined without second version
// - single-slice form undefined without base feature
// - single slice index plus offset mod elements
// - single-slice inactive destination elements stay unchanged; other forms write all bytes
// - governing predicate chosen from registers 0-7
// - tile index register from 011 plus field
// - tile number masked per element size
// - orientation bit zero horizontal, one vertical
// - 32-bit single slice uses two-bit offset
`timescale 1ns/1ps
`include "mvu_consts.svh"

module mvu_move_unit
    import mvu_pkg::*;
#(
    parameter int VL_MAX = 2048
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // feature presence
    input wire logic feat_base,
    input wire logic feat_v2,
    // current vector length code, vl_bits = 128 << vl_log2
    input wire logic [2:0] vl_log2,
    // decoded request
    input wire logic req_valid,
    input wire logic [1:0] req_form,
    input wire logic [2:0] req_esz_log2,
    input wire logic [3:0] req_offset_field,
    input wire logic [1:0] req_index_field,
    input wire logic [3:0] req_tile_field,
    input wire logic req_vertical,
    input wire logic [4:0] req_dest_field,
    input wire logic [2:0] req_pred_field,
    output logic req_ready,
    output logic undef_pulse,
    output logic done_pulse,
    // general register read, data one cycle after the enable
    output logic gpr_rd_en,
    output logic [4:0] gpr_rd_idx,
    input wire logic [`MVU_GPR_W-1:0] gpr_rd_data,
    // predicate register read, data one cycle after the enable
    output logic pred_rd_en,
    output logic [2:0] pred_rd_idx,
    input wire logic [VL_MAX/8-1:0] pred_rd_data,
    // matrix storage read, data one cycle after the enable
    output logic za_rd_en,
    output logic za_rd_array,
    output logic [3:0] za_rd_tile,
    output logic [2:0] za_rd_esz,
    output logic za_rd_vertical,
    output logic [`MVU_IDX_W-1:0] za_rd_addr,
    input wire logic [VL_MAX-1:0] za_rd_data,
    // vector register write with byte enables
    output logic vr_wr_en,
    output logic [4:0] vr_wr_idx,
    output logic [VL_MAX-1:0] vr_wr_data,
    output logic [VL_MAX/8-1:0] vr_wr_be
);
    localparam int NB = VL_MAX / 8;
    localparam int IW = `MVU_IDX_W;

    ////////////////////////////////////////////////////////////////////////////
    // state
    mvu_state_t state_r, state_nxt;
    mvu_form_t form_r, form_nxt;
    logic [2:0] esz_r, esz_nxt;
    logic [2:0] vl_r, vl_nxt;
    logic [IW-1:0] off_r, off_nxt;
    logic [1:0] nreg_log2_r, nreg_log2_nxt;
    logic [IW-1:0] addr_r, addr_nxt;
    logic [IW-1:0] step_r, step_nxt;
    logic [IW-1:0] mod_mask_r, mod_mask_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic [4:0] dest_r, dest_nxt;
    logic [4:0] pend_dest_r, pend_dest_nxt;
    logic pend_en_r, pend_en_nxt;
    logic [NB-1:0] pred_bits_r, pred_bits_nxt;
    logic req_ready_r, req_ready_nxt;
    logic undef_r, undef_nxt;
    logic done_r, done_nxt;
    logic gpr_rd_en_r, gpr_rd_en_nxt;
    logic [4:0] gpr_rd_idx_r, gpr_rd_idx_nxt;
    logic pred_rd_en_r, pred_rd_en_nxt;
    logic [2:0] pred_rd_idx_r, pred_rd_idx_nxt;
    logic za_rd_en_r, za_rd_en_nxt;
    logic za_rd_array_r, za_rd_array_nxt;
    logic [3:0] za_rd_tile_r, za_rd_tile_nxt;
    logic za_rd_vert_r, za_rd_vert_nxt;
    logic [IW-1:0] za_rd_addr_r, za_rd_addr_nxt;
    logic vr_wr_en_r, vr_wr_en_nxt;
    logic [4:0] vr_wr_idx_r, vr_wr_idx_nxt;
    logic [VL_MAX-1:0] vr_wr_data_r, vr_wr_data_nxt;
    logic [NB-1:0] vr_wr_be_r, vr_wr_be_nxt;

    logic [NB-1:0] pred_be;

    mvu_pred_expand #(
        .VL_MAX(VL_MAX)
    ) u_pred_expand (
        .pred_bits(pred_bits_r),
        .esz_log2(esz_r),
        .byte_en(pred_be)
    );

    ////////////////////////////////////////////////////////////////////////////
    // request decode helpers
    mvu_form_t in_form;
    logic is_multi;
    logic bad_esz;
    logic undef_req;
    logic [3:0] tile_mask;
    logic [IW-1:0] single_off_mask;
    logic [IW-1:0] in_off;
    logic [1:0] in_nreg_log2;
    logic [4:0] in_dest;
    logic [3:0] slices_log2;
    logic [3:0] stride_log2;
    logic [IW:0] slice_mask9;
    logic [IW:0] stride9;
    logic [IW-1:0] base;

    always_comb begin
        in_form = mvu_form_t'(req_form);
        is_multi = (in_form != MVU_FORM_SINGLE);
        // four-slice forms have no 128-bit class
        bad_esz = (req_esz_log2 < `MVU_ESZ_8)
            || (in_form == MVU_FORM_TILE4 && req_esz_log2 == `MVU_ESZ_128)
            || (vl_log2 > `MVU_VL_MAX_CODE);
        undef_req = (is_multi && !feat_v2)
            || (!is_multi && !feat_base)
            || (in_form == MVU_FORM_TILE4 && req_esz_log2 == `MVU_ESZ_64
                && vl_log2 == `MVU_VL_128)
            || ((in_form == MVU_FORM_TILE4 || !is_multi) && bad_esz);
        // tile count: 1, 2, 4, 8, 16 tiles for 8..128-bit elements
        tile_mask = 4'((5'h01 << (req_esz_log2 - `MVU_ESZ_8)) - 5'h01);
        // single offset range: elements in a 128-bit segment minus one
        single_off_mask = IW'((9'h010 >> (req_esz_log2 - `MVU_ESZ_8)) - 9'h001);
        in_off = '0;
        in_nreg_log2 = `MVU_NREG1_LOG2;
        in_dest = req_dest_field;
        unique case (in_form)
            MVU_FORM_TILE4: begin
                in_nreg_log2 = `MVU_NREG4_LOG2;
                in_dest = {req_dest_field[2:0], 2'b00};
                if (req_esz_log2 == `MVU_ESZ_8) begin
                    in_off = {4'h0, req_offset_field[1:0], 2'b00};
                end else if (req_esz_log2 == `MVU_ESZ_16) begin
                    in_off = {5'h00, req_offset_field[0], 2'b00};
                end else begin
                    in_off = '0;
                end
            end
            MVU_FORM_ARRAY2: begin
                in_nreg_log2 = `MVU_NREG2_LOG2;
                in_dest = {req_dest_field[3:0], 1'b0};
                in_off = {5'h00, req_offset_field[2:0]};
            end
            MVU_FORM_ARRAY4: begin
                in_nreg_log2 = `MVU_NREG4_LOG2;
                in_dest = {req_dest_field[2:0], 2'b00};
                in_off = {5'h00, req_offset_field[2:0]};
            end
            MVU_FORM_SINGLE: begin
                // 32-bit case keeps the two-bit field through the mask
                in_off = {4'h0, req_offset_field} & single_off_mask;
            end
        endcase
    end

    // address arithmetic on the latched request and the index register value
    always_comb begin
        slices_log2 = `MVU_VL_BASE_LOG2 + {1'b0, vl_r} - {1'b0, esz_r};
        slice_mask9 = (9'h001 << slices_log2) - 9'h001;
        // array vectors = vl / 8, stride = vectors / nreg
        stride_log2 = `MVU_VL_BASE_LOG2 - `MVU_BYTE_LOG2 + {1'b0, vl_r}
            - {2'b00, nreg_log2_r};
        stride9 = 9'h001 << stride_log2;
        base = '0;
        unique case (form_r)
            MVU_FORM_TILE4: begin
                base = ((gpr_rd_data[IW-1:0] & `MVU_TILE4_ALIGN) + off_r)
                    & slice_mask9[IW-1:0];
            end
            MVU_FORM_ARRAY2, MVU_FORM_ARRAY4: begin
                // each register reads its own half or quarter of the array
                base = (gpr_rd_data[IW-1:0] + off_r)
                    & IW'(stride9 - 9'h001);
            end
            MVU_FORM_SINGLE: begin
                base = (gpr_rd_data[IW-1:0] + off_r) & slice_mask9[IW-1:0];
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: cycle count depends only on the form, never on data
    always_comb begin
        state_nxt = state_r;
        form_nxt = form_r;
        esz_nxt = esz_r;
        vl_nxt = vl_r;
        off_nxt = off_r;
        nreg_log2_nxt = nreg_log2_r;
        addr_nxt = addr_r;
        step_nxt = step_r;
        mod_mask_nxt = mod_mask_r;
        cnt_nxt = cnt_r;
        dest_nxt = dest_r;
        pred_bits_nxt = pred_bits_r;
        undef_nxt = 1'b0;
        done_nxt = 1'b0;
        gpr_rd_en_nxt = 1'b0;
        gpr_rd_idx_nxt = gpr_rd_idx_r;
        pred_rd_en_nxt = 1'b0;
        pred_rd_idx_nxt = pred_rd_idx_r;
        za_rd_en_nxt = 1'b0;
        za_rd_array_nxt = za_rd_array_r;
        za_rd_tile_nxt = za_rd_tile_r;
        za_rd_vert_nxt = za_rd_vert_r;
        za_rd_addr_nxt = za_rd_addr_r;
        unique case (state_r)
            MVU_ST_IDLE: begin
                if (req_valid) begin
                    if (undef_req) begin
                        undef_nxt = 1'b1;
                    end else begin
                        state_nxt = MVU_ST_WAIT_REG;
                        form_nxt = in_form;
                        esz_nxt = req_esz_log2;
                        vl_nxt = vl_log2;
                        off_nxt = in_off;
                        nreg_log2_nxt = in_nreg_log2;
                        dest_nxt = in_dest;
                        za_rd_array_nxt = (in_form == MVU_FORM_ARRAY2)
                            || (in_form == MVU_FORM_ARRAY4);
                        za_rd_tile_nxt = req_tile_field & tile_mask;
                        za_rd_vert_nxt = req_vertical;
                        gpr_rd_en_nxt = 1'b1;
                        if (za_rd_array_nxt) begin
                            gpr_rd_idx_nxt = {`MVU_SEL_PREFIX, req_index_field};
                        end else begin
                            gpr_rd_idx_nxt = {`MVU_IDX_PREFIX, req_index_field};
                        end
                        // predicate read always issued to keep timing uniform
                        pred_rd_en_nxt = 1'b1;
                        pred_rd_idx_nxt = req_pred_field;
                    end
                end
            end
            MVU_ST_WAIT_REG: begin
                state_nxt = MVU_ST_CALC;
            end
            MVU_ST_CALC: begin
                pred_bits_nxt = pred_rd_data;
                za_rd_en_nxt = 1'b1;
                za_rd_addr_nxt = base;
                step_nxt = za_rd_array_r ? stride9[IW-1:0] : IW'(1);
                mod_mask_nxt = za_rd_array_r ? 8'hff : slice_mask9[IW-1:0];
                addr_nxt = base + (za_rd_array_r ? stride9[IW-1:0] : IW'(1));
                cnt_nxt = 3'h1;
                state_nxt = (nreg_log2_r == `MVU_NREG1_LOG2) ? MVU_ST_DRAIN : MVU_ST_XFER;
            end
            MVU_ST_XFER: begin
                // tile slices wrap modulo the slice count
                za_rd_en_nxt = 1'b1;
                za_rd_addr_nxt = addr_r & mod_mask_r;
                addr_nxt = addr_r + step_r;
                cnt_nxt = cnt_r + 3'h1;
                if (cnt_r == 3'((4'h1 << nreg_log2_r) - 4'h1)) begin
                    state_nxt = MVU_ST_DRAIN;
                end
            end
            MVU_ST_DRAIN: begin
                if (pend_en_r && !za_rd_en_r) begin
                    state_nxt = MVU_ST_IDLE;
                    done_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt = MVU_ST_IDLE;
            end
        endcase
        req_ready_nxt = (state_nxt == MVU_ST_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////////
    // writeback: one vector register per returned slice, consecutive indices
    always_comb begin
        pend_en_nxt = za_rd_en_r;
        pend_dest_nxt = pend_dest_r;
        if (state_r == MVU_ST_CALC) begin
            pend_dest_nxt = dest_r;
        end else if (pend_en_r) begin
            pend_dest_nxt = pend_dest_r + 5'h01;
        end
        vr_wr_en_nxt = pend_en_r;
        vr_wr_idx_nxt = pend_dest_r;
        vr_wr_data_nxt = za_rd_data;
        // merging for the single form: only active elements are written; other forms write all bytes
        vr_wr_be_nxt = (form_r == MVU_FORM_SINGLE) ? pred_be : '1;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= MVU_ST_IDLE;
            form_r <= MVU_FORM_TILE4;
            esz_r <= `MVU_ESZ_8;
            vl_r <= `MVU_VL_128;
            off_r <= '0;
            nreg_log2_r <= `MVU_NREG1_LOG2;
            addr_r <= '0;
            step_r <= '0;
            mod_mask_r <= '0;
            cnt_r <= '0;
            dest_r <= '0;
            pend_dest_r <= '0;
            pend_en_r <= 1'b0;
            pred_bits_r <= '0;
            req_ready_r <= 1'b1;
            undef_r <= 1'b0;
            done_r <= 1'b0;
            gpr_rd_en_r <= 1'b0;
            gpr_rd_idx_r <= '0;
            pred_rd_en_r <= 1'b0;
            pred_rd_idx_r <= '0;
            za_rd_en_r <= 1'b0;
            za_rd_array_r <= 1'b0;
            za_rd_tile_r <= '0;
            za_rd_vert_r <= 1'b0;
            za_rd_addr_r <= '0;
            vr_wr_en_r <= 1'b0;
            vr_wr_idx_r <= '0;
            vr_wr_data_r <= '0;
            vr_wr_be_r <= '0;
        end else begin
            state_r <= state_nxt;
            form_r <= form_nxt;
            esz_r <= esz_nxt;
            vl_r <= vl_nxt;
            off_r <= off_nxt;
            nreg_log2_r <= nreg_log2_nxt;
            addr_r <= addr_nxt;
            step_r <= step_nxt;
            mod_mask_r <= mod_mask_nxt;
            cnt_r <= cnt_nxt;
            dest_r <= dest_nxt;
            pend_dest_r <= pend_dest_nxt;
            pend_en_r <= pend_en_nxt;
            pred_bits_r <= pred_bits_nxt;
            req_ready_r <= req_ready_nxt;
            undef_r <= undef_nxt;
            done_r <= done_nxt;
            gpr_rd_en_r <= gpr_rd_en_nxt;
            gpr_rd_idx_r <= gpr_rd_idx_nxt;
            pred_rd_en_r <= pred_rd_en_nxt;
            pred_rd_idx_r <= pred_rd_idx_nxt;
            za_rd_en_r <= za_rd_en_nxt;
            za_rd_array_r <= za_rd_array_nxt;
            za_rd_tile_r <= za_rd_tile_nxt;
            za_rd_vert_r <= za_rd_vert_nxt;
            za_rd_addr_r <= za_rd_addr_nxt;
            vr_wr_en_r <= vr_wr_en_nxt;
            vr_wr_idx_r <= vr_wr_idx_nxt;
            vr_wr_data_r <= vr_wr_data_nxt;
            vr_wr_be_r <= vr_wr_be_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign req_ready = req_ready_r;
    assign undef_pulse = undef_r;
    assign done_pulse = done_r;
    assign gpr_rd_en = gpr_rd_en_r;
    assign gpr_rd_idx = gpr_rd_idx_r;
    assign pred_rd_en = pred_rd_en_r;
    assign pred_rd_idx = pred_rd_idx_r;
    assign za_rd_en = za_rd_en_r;
    assign za_rd_array = za_rd_array_r;
    assign za_rd_tile = za_rd_tile_r;
    assign za_rd_esz = esz_r;
    assign za_rd_vertical = za_rd_vert_r;
    assign za_rd_addr = za_rd_addr_r;
    assign vr_wr_en = vr_wr_en_r;
    assign vr_wr_idx = vr_wr_idx_r;
    assign vr_wr_data = vr_wr_data_r;
    assign vr_wr_be = vr_wr_be_r;

endmodule

/* core/mvu_consts.svh */
// constants for the matrix-to-vector move unit
`ifndef MVU_CONSTS_SVH
`define MVU_CONSTS_SVH

// element size codes (log2 of element bits)
`define MVU_ESZ_8 3'h3
`define MVU_ESZ_16 3'h4
`define MVU_ESZ_32 3'h5
`define MVU_ESZ_64 3'h6
`define MVU_ESZ_128 3'h7

// vector length code: vl_bits = 128 << vl_log2
`define MVU_VL_BASE_LOG2 4'h7
`define MVU_VL_128 3'h0
`define MVU_VL_MAX_CODE 3'h4

// log2 of the byte width, used for the array vector count (vl / 8)
`define MVU_BYTE_LOG2 4'h3

// general register prefixes for the index and select fields
`define MVU_SEL_PREFIX 3'h2
`define MVU_IDX_PREFIX 3'h3

// register count codes (log2)
`define MVU_NREG1_LOG2 2'h0
`define MVU_NREG2_LOG2 2'h1
`define MVU_NREG4_LOG2 2'h2

// four-slice form: slice alignment mask
`define MVU_TILE4_ALIGN 8'hfc

// widths
`define MVU_GPR_W 32
`define MVU_IDX_W 8

`endif

/* core/mvu_pkg.sv */
// types for the matrix-to-vector move unit
package mvu_pkg;

    typedef enum logic [1:0] {
        MVU_FORM_TILE4 = 2'h0,
        MVU_FORM_ARRAY2 = 2'h1,
        MVU_FORM_ARRAY4 = 2'h2,
        MVU_FORM_SINGLE = 2'h3
    } mvu_form_t;

    typedef enum logic [2:0] {
        MVU_ST_IDLE = 3'h0,
        MVU_ST_WAIT_REG = 3'h1,
        MVU_ST_CALC = 3'h2,
        MVU_ST_XFER = 3'h3,
        MVU_ST_DRAIN = 3'h4
    } mvu_state_t;

endpackage

/* core/mvu_pred_expand.sv */
// predicate-to-byte-enable expander for the merging single-slice move
`timescale 1ns/1ps
`include "mvu_consts.svh"

module mvu_pred_expand #(
    parameter int VL_MAX = 2048
) (
    // one predicate bit per byte of the vector
    input wire logic [VL_MAX/8-1:0] pred_bits,
    // element size code
    input wire logic [2:0] esz_log2,
    // byte write enables, one per byte
    output logic [VL_MAX/8-1:0] byte_en
);
    localparam int NB = VL_MAX / 8;
    localparam int BW = $clog2(NB);

    logic [BW-1:0] low_mask;

    // the leading byte's predicate bit governs the whole element
    assign low_mask = BW'((32'h0000_0001 << (esz_log2 - `MVU_ESZ_8)) - 32'h0000_0001);

    genvar b;
    generate
        for (b = 0; b < NB; b = b + 1) begin : g_byte
            localparam logic [BW-1:0] BIDX = BW'(b);
            assign byte_en[b] = pred_bits[BIDX & ~low_mask];
        end
    endgenerate

endmodule

/* verif/mvu_move_unit_sva.sv */
// assertion checker for the matrix-to-vector move unit
`timescale 1ns/1ps
module mvu_move_unit_chk
    import mvu_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // request side
    input wire logic feat_base,
    input wire logic feat_v2,
    input wire logic [2:0] vl_log2,
    input wire logic req_valid,
    input wire logic [1:0] req_form,
    input wire logic [2:0] req_esz_log2,
    input wire logic [1:0] req_index_field,
    input wire logic req_vertical,
    input wire logic [4:0] req_dest_field,
    input wire logic [2:0] req_pred_field,
    input wire logic req_ready,
    input wire logic undef_pulse,
    input wire logic done_pulse,
    // register reads and writes
    input wire logic gpr_rd_en,
    input wire logic [4:0] gpr_rd_idx,
    input wire logic pred_rd_en,
    input wire logic [2:0] pred_rd_idx,
    input wire logic za_rd_en,
    input wire logic za_rd_vertical,
    input wire logic vr_wr_en,
    input wire logic [4:0] vr_wr_idx
);
default clocking @(posedge clk_sys); endclocking
default disable iff (!rst_n);
logic take;
logic arr_ok;
logic sgl_ok;
logic t4_ok;
logic [2:0] dest_lo;
assign take = req_valid && req_ready && (vl_log2 <= 3'h4);
assign arr_ok = take && feat_v2 && (req_form == MVU_FORM_ARRAY2 || req_form == MVU_FORM_ARRAY4);
assign sgl_ok = take && feat_base && req_form == MVU_FORM_SINGLE && req_esz_log2 >= 3'h3;
assign t4_ok = take && feat_v2 && req_form == MVU_FORM_TILE4 && req_esz_log2 >= 3'h3
    && req_esz_log2 <= 3'h5;
assign dest_lo = req_dest_field[2:0];
////////////////////////////////////////////////////////////////////////////////
property p_sel_reg;
    arr_ok |=> gpr_rd_en && gpr_rd_idx == {3'h2, $past(req_index_field)};
endproperty
a_sel_reg: assert property (p_sel_reg) else $error("select register wrong");
property p_idx_reg;
    (t4_ok || sgl_ok) |=> gpr_rd_en && gpr_rd_idx == {3'h3, $past(req_index_field)};
endproperty
a_idx_reg: assert property (p_idx_reg) else $error("index register wrong");
property p_undef_v2;
    take && !feat_v2 && req_form != MVU_FORM_SINGLE |=> undef_pulse && !gpr_rd_en && req_ready;
endproperty
a_undef_v2: assert property (p_undef_v2) else $error("multi form accepted");
property p_undef_base;
    take && !feat_base && req_form == MVU_FORM_SINGLE |=> undef_pulse && !gpr_rd_en;
endproperty
a_undef_base: assert property (p_undef_base) else $error("single form accepted");
property p_undef_vl;
    take && req_form == MVU_FORM_TILE4 && req_esz_log2 == 3'h6 && vl_log2 == 3'h0 |=> undef_pulse;
endproperty
a_undef_vl: assert property (p_undef_vl) else $error("64-bit four slice accepted");
property p_latency2;
    arr_ok && req_form == MVU_FORM_ARRAY2 |=> !done_pulse [*5] ##1 done_pulse;
endproperty
a_latency2: assert property (p_latency2) else $error("two-reg latency wrong");
property p_dest4;
    arr_ok && req_form == MVU_FORM_ARRAY4 |-> ##5 vr_wr_en && vr_wr_idx == {$past(dest_lo, 5), 2'b00};
endproperty
a_dest4: assert property (p_dest4) else $error("four-reg destination wrong");
property p_pred_sel;
    sgl_ok |=> pred_rd_en && pred_rd_idx == $past(req_pred_field);
endproperty
a_pred_sel: assert property (p_pred_sel) else $error("predicate select wrong");
property p_vert;
    sgl_ok |-> ##3 za_rd_en && za_rd_vertical == $past(req_vertical, 3);
endproperty
a_vert: assert property (p_vert) else $error("orientation wrong");
c_arr4: cover property (arr_ok && req_form == MVU_FORM_ARRAY4);
c_sgl: cover property (sgl_ok);
c_undef: cover property (undef_pulse);
endmodule
bind mvu_move_unit mvu_move_unit_chk u_chk (.clk_sys, .rst_n, .feat_base, .feat_v2, .vl_log2,
    .req_valid, .req_form, .req_esz_log2, .req_index_field, .req_vertical, .req_dest_field,
    .req_pred_field, .req_ready, .undef_pulse, .done_pulse, .gpr_rd_en, .gpr_rd_idx, .pred_rd_en,
    .pred_rd_idx, .za_rd_en, .za_rd_vertical, .vr_wr_en, .vr_wr_idx);

/* verif/testbench.sv */
// self-checking testbench for the matrix-to-vector move unit
`timescale 1ns/1ps
module testbench;
logic clk_sys, rst_n, feat_base, feat_v2, req_valid, req_vertical, req_ready, undef_pulse;
logic done_pulse, gpr_rd_en, pred_rd_en, za_rd_en, za_rd_array, za_rd_vertical, vr_wr_en;
logic [2:0] vl_log2, req_esz_log2, req_pred_field, pred_rd_idx, za_rd_esz;
logic [1:0] req_form, req_index_field;
logic [3:0] req_offset_field, req_tile_field, za_rd_tile;
logic [4:0] req_dest_field, gpr_rd_idx, vr_wr_idx;
logic [31:0] gpr_rd_data, gval;
logic [255:0] pred_rd_data, pval, vr_wr_be;
logic [2047:0] za_rd_data, vr_wr_data;
logic [7:0] za_rd_addr, a_d;
logic za_d, g_d, p_d;
int fails, comparisons;
mvu_move_unit uut (.clk_sys(clk_sys), .rst_n(rst_n), .feat_base(feat_base), .feat_v2(feat_v2),
    .vl_log2(vl_log2), .req_valid(req_valid), .req_form(req_form), .req_esz_log2(req_esz_log2),
    .req_offset_field(req_offset_field), .req_index_field(req_index_field),
    .req_tile_field(req_tile_field), .req_vertical(req_vertical), .req_dest_field(req_dest_field),
    .req_pred_field(req_pred_field), .req_ready(req_ready), .undef_pulse(undef_pulse),
    .done_pulse(done_pulse), .gpr_rd_en(gpr_rd_en), .gpr_rd_idx(gpr_rd_idx),
    .gpr_rd_data(gpr_rd_data), .pred_rd_en(pred_rd_en), .pred_rd_idx(pred_rd_idx),
    .pred_rd_data(pred_rd_data), .za_rd_en(za_rd_en), .za_rd_array(za_rd_array),
    .za_rd_tile(za_rd_tile), .za_rd_esz(za_rd_esz), .za_rd_vertical(za_rd_vertical),
    .za_rd_addr(za_rd_addr), .za_rd_data(za_rd_data), .vr_wr_en(vr_wr_en), .vr_wr_idx(vr_wr_idx),
    .vr_wr_data(vr_wr_data), .vr_wr_be(vr_wr_be));
////////////////////////////////////////////////////////////////////////////////
initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
end
function automatic logic [2047:0] pat(input logic [7:0] a);
    return {128{a, ~a}};
endfunction
// register files: data valid the cycle after each enable, scrambled otherwise
always @(negedge clk_sys) begin
    za_rd_data <= za_d ? pat(a_d) : ~pat(a_d);
    gpr_rd_data <= g_d ? gval : ~gval;
    pred_rd_data <= p_d ? pval : ~pval;
    za_d <= za_rd_en;
    a_d <= za_rd_addr;
    g_d <= gpr_rd_en;
    p_d <= pred_rd_en;
end
function automatic bit ok(input bit c);
    comparisons++;
    return c;
endfunction
task err(input string m);
    fails++;
    $display("ERROR at %0t: %s", $time, m);
endtask
task results;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////////
task run(input string nm, input logic [1:0] form, input logic [2:0] esz, input logic [3:0] off,
    input logic [1:0] idxf, input logic [3:0] tile, input logic vert, input logic [4:0] dest,
    input logic [31:0] gv, input logic [7:0] a0, input logic [7:0] step, input int n,
    input logic [4:0] d0, input logic [3:0] etile, input logic [15:0] ebe, input logic und);
    int rd, wr, k;
    logic gu, dn;
    logic [2:0] pfx;
    logic [2047:0] ev;
    rd = 0;
    wr = 0;
    gu = 0;
    dn = 0;
    pfx = (form == 2'h1 || form == 2'h2) ? 3'h2 : 3'h3;
    gval = gv;
    {req_form, req_esz_log2, req_offset_field, req_index_field} = {form, esz, off, idxf};
    {req_tile_field, req_vertical, req_dest_field, req_valid} = {tile, vert, dest, 1'b1};
    @(negedge clk_sys);
    req_valid = 1'b0;
    for (k = 1; k <= 12 && !dn; k++) begin
        if (undef_pulse === 1'b1) gu = 1'b1;
        if (gpr_rd_en === 1'b1)
            if (!ok(gpr_rd_idx === {pfx, idxf})) err("index register");
        if (za_rd_en === 1'b1) begin
            if (!ok(za_rd_addr === 8'(a0 + step * rd))) err("read address");
            if (pfx == 3'h3)
                if (!ok({za_rd_tile, za_rd_vertical} === {etile, vert})) err("tile");
            if (!ok({za_rd_array, za_rd_esz} === {pfx == 3'h2, esz}))
                err("array or size");
            rd++;
        end
        if (vr_wr_en === 1'b1) begin
            ev = pat(8'(a0 + step * wr));
            if (!ok(vr_wr_idx === 5'(d0 + wr))) err("destination");
            if (!ok(vr_wr_data[127:0] === ev[127:0])) err("write data");
            if (!ok(vr_wr_be[15:0] === ebe)) err("byte enables");
            wr++;
        end
        if (done_pulse === 1'b1) begin
            dn = 1'b1;
            if (!ok(k == 4 + n && wr == n)) err("latency");
        end
        if (!dn) @(negedge clk_sys);
    end
    if (und) begin
        if (!ok(gu && rd == 0 && req_ready === 1'b1)) err("not refused");
    end else if (!dn) begin
        err("no completion");
        results;
    end
    $display("test %s done", nm);
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    {fails, comparisons, gval, pval} = '0;
    {feat_base, feat_v2, vl_log2, req_valid, req_pred_field, rst_n} = {2'b11, 3'h4, 5'h0};
    {req_form, req_esz_log2, req_offset_field, req_index_field} = '0;
    {req_tile_field, req_vertical, req_dest_field} = '0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    if (!ok(req_ready === 1'b1 && vr_wr_en === 1'b0)) err("reset state");
    run("tile8", 2'h0, 3'h3, 4'h3, 2'h1, 4'h0, 0, 5'h1, 32'h2d, 8'd56, 8'd1, 4, 5'd4,
        4'h0, 16'hffff, 0);
    run("tile16", 2'h0, 3'h4, 4'h1, 2'h2, 4'hf, 1, 5'h1a, 32'd127, 8'd0, 8'd1, 4, 5'd8,
        4'h1, 16'hffff, 0);
    run("tile32", 2'h0, 3'h5, 4'h3, 2'h3, 4'h6, 0, 5'h7, 32'd5, 8'd4, 8'd1, 4, 5'd28,
        4'h2, 16'hffff, 0);
    run("array2", 2'h1, 3'h3, 4'h7, 2'h2, 4'h0, 0, 5'h5, 32'h1f9, 8'd0, 8'd128, 2, 5'd10,
        4'h0, 16'hffff, 0);
    run("array4", 2'h2, 3'h3, 4'h5, 2'h0, 4'h0, 0, 5'h3, 32'd60, 8'd1, 8'd64, 4, 5'd12,
        4'h0, 16'hffff, 0);
    {vl_log2, req_pred_field, pval[15:0]} = {3'h0, 3'h5, 16'h2112};
    run("single", 2'h3, 3'h5, 4'h3, 2'h1, 4'hf, 1, 5'd17, 32'd2, 8'd1, 8'd0, 1, 5'd17,
        4'h3, 16'h0ff0, 0);
    run("undef64", 2'h0, 3'h6, 4'h0, 2'h0, 4'h0, 0, 5'h0, 32'd0, 8'd0, 8'd0, 4, 5'd0,
        4'h0, 16'hffff, 1);
    feat_v2 = 1'b0;
    run("undefv2", 2'h1, 3'h3, 4'h0, 2'h0, 4'h0, 0, 5'h0, 32'd0, 8'd0, 8'd0, 2, 5'd0,
        4'h0, 16'hffff, 1);
    {feat_v2, feat_base} = 2'b10;
    run("undefbase", 2'h3, 3'h5, 4'h0, 2'h0, 4'h0, 0, 5'h0, 32'd0, 8'd0, 8'd0, 1, 5'd0,
        4'h0, 16'hffff, 1);
    results;
end
endmodule
